// >>> rtl/pss_pkg.sv
/*
  Package of the parameter-set sequencer: register map, field positions,
  reset values, timing counts, source and state encodings, and the packed
  structs that carry the APB request, the APB answer and all module state.
  Assumes a single 50 MHz core clock and an APB master with 32-bit data.
*/
package pss_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths and sizes
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned PARAM_W = 16;
  localparam int unsigned SET_NUM = 64;
  localparam int unsigned IDX_W   = 6;
  localparam int unsigned CNT_W   = 7;
  localparam int unsigned SETL_W  = 6;
  localparam int unsigned SYNC_W  = 3;
  localparam int unsigned LINE_W  = 2;

  localparam logic [SETL_W-1:0] SETTLE_LOAD = SETL_W'(SETTLE_CYC);
  localparam logic [SETL_W-1:0] SETTLE_NONE = 6'h00;

  // Set counts and indices
  localparam logic [CNT_W-1:0]   MIN_SETS      = 7'h01;
  localparam logic [CNT_W-1:0]   CTRL_MAX_SETS = 7'h40;
  localparam logic [CNT_W-1:0]   FREE_MAX_SETS = 7'h04;
  localparam logic [CNT_W-1:0]   TWO_SETS      = 7'h02;
  localparam logic [CNT_W-1:0]   CNT_RST       = 7'h01;
  localparam logic [IDX_W-1:0]   FIRST_SET     = 6'h00;
  localparam logic [IDX_W-1:0]   LAST_SET      = 6'h3f;
  localparam logic [PARAM_W-1:0] PARAM_DEFAULT = 16'h0000;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ORIGIN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PTR    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INVERT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int unsigned CTRL_ON_BIT     = 0;
  localparam int unsigned CTRL_POLICY_BIT = 1;
  localparam int unsigned CMD_SAVE_BIT    = 0;
  localparam int unsigned CMD_COPY_BIT    = 1;
  localparam int unsigned ST_WAIT_BIT     = 0;
  localparam int unsigned ST_RUN_BIT      = 1;
  localparam int unsigned ST_DRAIN_BIT    = 2;
  localparam int unsigned ST_CUR_LSB      = 8;

  // Policy and target encodings
  localparam logic POLICY_CTRL = 1'b0;
  localparam logic POLICY_FREE = 1'b1;
  localparam logic TGT_ADVANCE = 1'b0;
  localparam logic TGT_RESTART = 1'b1;

  typedef enum logic [1:0] {SRC_DISABLED, SRC_ALWAYS, SRC_LINE1, SRC_LINE2} pss_src_e;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} pss_state_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } pss_apb_req_s;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } pss_apb_rsp_s;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
  } pss_sync_s;

  typedef struct packed {
    pss_state_e                      st;
    logic                            on;
    logic                            policy;
    logic [CNT_W-1:0]                count;
    logic                            target;
    pss_src_e                        adv_src;
    pss_src_e                        rst_src;
    pss_src_e                        bit0_src;
    pss_src_e                        bit1_src;
    logic [IDX_W-1:0]                pointer;
    logic [LINE_W-1:0]               inv;
    logic [PARAM_W-1:0]              active;
    logic [PARAM_W-1:0]              backup;
    logic [IDX_W-1:0]                cur;
    logic                            loading;
    logic                            waiting;
    logic [SETL_W-1:0]               settle;
    logic [DATA_W-1:0]               prdata;
    logic [SET_NUM-1:0][PARAM_W-1:0] sets;
  } pss_core_s;

endpackage : pss_pkg

// >>> rtl/pss_sequencer.sv
/*
  Parameter-set sequencer core: APB register file, 64 stored parameter
  sets, active set with backup, controlled and free-selection switching
  on frame start triggers, and a waiting-for-trigger status.
  Assumes frame_busy is high from exposure start to end of transmission,
  and that lines and trigger are asynchronous levels from the camera I/O.
*/
`timescale 1ns/100ps
module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire pss_pkg::pss_apb_req_s         apb_req,
  output pss_pkg::pss_apb_rsp_s              apb_rsp,
  input  wire logic [pss_pkg::LINE_W-1:0]    input_line,
  input  wire logic                          frame_trigger,
  input  wire logic                          frame_busy,
  output logic      [pss_pkg::PARAM_W-1:0]   active_params,
  output logic      [pss_pkg::IDX_W-1:0]     current_set,
  output logic                               waiting_for_trigger,
  output logic                               sequencer_running
);
  import pss_pkg::*;

  pss_core_s          q;
  pss_core_s          next_q;
  logic [SYNC_W-1:0]  sy_level;
  logic [SYNC_W-1:0]  sy_rise;
  logic [SYNC_W-1:0]  sy_change;
  logic [LINE_W-1:0]  line_val;
  logic [LINE_W-1:0]  line_chg;
  logic               trig_rise;
  logic               setup;
  logic               access;
  logic               wr;
  logic               wr_err;
  logic [IDX_W-1:0]   free_addr;
  logic [IDX_W-1:0]   ctrl_next;
  logic               addr_chg;
  logic [DATA_W-1:0]  rd_word;

  // Line 1 sits in bit 0, line 2 in bit 1, trigger on top
  pss_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .raw      ({frame_trigger, input_line}),
    .level    (sy_level),
    .rise     (sy_rise),
    .change   (sy_change)
  );

  // Picks the bit a source stands for; used for levels and for changes alike
  function automatic logic src_hit(input pss_src_e src, input logic [LINE_W-1:0] v);
    case (src)
      SRC_ALWAYS: src_hit = 1'b1;
      SRC_LINE1:  src_hit = v[0];
      SRC_LINE2:  src_hit = v[1];
      default:    src_hit = 1'b0;
    endcase
  endfunction : src_hit

  // Synchronised levels with per-line invert, trigger edge
  assign line_val  = sy_level[LINE_W-1:0] ^ q.inv;
  assign line_chg  = sy_change[LINE_W-1:0];
  assign trig_rise = sy_rise[LINE_W];

  // Free-selection address: bit 1 used only above two sets
  always_comb begin
    free_addr    = FIRST_SET;
    free_addr[0] = src_hit(q.bit0_src, line_val);
    free_addr[1] = (q.count > TWO_SETS) ? src_hit(q.bit1_src, line_val) : 1'b0;
    addr_chg     = src_hit(q.bit0_src, line_chg) |
                   ((q.count > TWO_SETS) & src_hit(q.bit1_src, line_chg));
  end

  // Controlled mode: restart beats advance, advance wraps at the set count
  always_comb begin
    ctrl_next = q.cur;
    if (src_hit(q.rst_src, line_val)) begin
      ctrl_next = FIRST_SET;
    end else if (src_hit(q.adv_src, line_val)) begin
      if (({1'b0, q.cur} + MIN_SETS) >= q.count) begin
        ctrl_next = FIRST_SET;
      end else begin
        ctrl_next = IDX_W'(q.cur + 1'b1);
      end
    end
  end

  // APB phase decode
  assign setup  = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wr     = access & apb_req.pwrite;

  // Read mux, captured in the setup phase so prdata comes from a flop
  always_comb begin
    rd_word = '0;
    case (apb_req.paddr)
      OFS_CTRL: begin
        rd_word[CTRL_ON_BIT]     = q.on;
        rd_word[CTRL_POLICY_BIT] = q.policy;
      end
      OFS_COUNT:  rd_word[CNT_W-1:0] = q.count;
      OFS_TARGET: rd_word[0] = q.target;
      OFS_ORIGIN: begin
        if (q.policy == POLICY_FREE) begin
          rd_word[1:0] = (q.target == TGT_ADVANCE) ? q.bit0_src : q.bit1_src;
        end else begin
          rd_word[1:0] = (q.target == TGT_ADVANCE) ? q.adv_src : q.rst_src;
        end
      end
      OFS_PTR:    rd_word[IDX_W-1:0] = q.pointer;
      OFS_ACTIVE: rd_word[PARAM_W-1:0] = q.active;
      OFS_INVERT: rd_word[LINE_W-1:0] = q.inv;
      OFS_STATUS: begin
        rd_word[ST_WAIT_BIT]                   = q.waiting;
        rd_word[ST_RUN_BIT]                    = (q.st == ST_RUN);
        rd_word[ST_DRAIN_BIT]                  = (q.st == ST_DRAIN);
        rd_word[ST_CUR_LSB +: IDX_W]           = q.cur;
      end
      default: rd_word = '0;
    endcase
  end

  // Write refusal: bad values are dropped and flagged with pslverr
  always_comb begin
    wr_err = 1'b0;
    case (apb_req.paddr)
      OFS_CTRL:   wr_err = apb_req.pwdata[CTRL_POLICY_BIT] && (q.count > FREE_MAX_SETS);
      OFS_COUNT: begin
        if (apb_req.pwdata[DATA_W-1:CNT_W] != '0 || apb_req.pwdata[CNT_W-1:0] < MIN_SETS) begin
          wr_err = 1'b1;
        end else if (q.policy == POLICY_FREE) begin
          wr_err = apb_req.pwdata[CNT_W-1:0] > FREE_MAX_SETS;
        end else begin
          wr_err = apb_req.pwdata[CNT_W-1:0] > CTRL_MAX_SETS;
        end
      end
      OFS_TARGET: wr_err = 1'b0;
      OFS_ORIGIN: begin
        if (q.policy == POLICY_FREE) begin
          wr_err = !(apb_req.pwdata[1:0] == SRC_LINE1 || apb_req.pwdata[1:0] == SRC_LINE2);
        end else begin
          wr_err = (q.target == TGT_RESTART) && (apb_req.pwdata[1:0] == SRC_ALWAYS);
        end
      end
      OFS_PTR:    wr_err = apb_req.pwdata[DATA_W-1:IDX_W] != '0;
      OFS_CMD:    wr_err = 1'b0;
      OFS_ACTIVE: wr_err = 1'b0;
      OFS_INVERT: wr_err = 1'b0;
      default:    wr_err = 1'b1;
    endcase
  end

  // Next state: register writes first, then the sequencer takes the active set
  always_comb begin
    next_q         = q;
    next_q.loading = 1'b0;
    if (setup) begin
      next_q.prdata = rd_word;
    end
    if (q.settle != SETTLE_NONE) begin
      next_q.settle = SETL_W'(q.settle - 1'b1);
    end
    if (wr && !wr_err) begin
      case (apb_req.paddr)
        OFS_CTRL: begin
          next_q.on     = apb_req.pwdata[CTRL_ON_BIT];
          next_q.policy = apb_req.pwdata[CTRL_POLICY_BIT];
        end
        OFS_COUNT:  next_q.count = apb_req.pwdata[CNT_W-1:0];
        OFS_TARGET: next_q.target = apb_req.pwdata[0];
        OFS_ORIGIN: begin
          if (q.policy == POLICY_FREE && q.target == TGT_ADVANCE) begin
            next_q.bit0_src = pss_src_e'(apb_req.pwdata[1:0]);
          end else if (q.policy == POLICY_FREE) begin
            next_q.bit1_src = pss_src_e'(apb_req.pwdata[1:0]);
          end else if (q.target == TGT_ADVANCE) begin
            next_q.adv_src = pss_src_e'(apb_req.pwdata[1:0]);
          end else begin
            next_q.rst_src = pss_src_e'(apb_req.pwdata[1:0]);
          end
        end
        OFS_PTR:    next_q.pointer = apb_req.pwdata[IDX_W-1:0];
        OFS_CMD: begin
          if (apb_req.pwdata[CMD_SAVE_BIT]) begin
            next_q.sets[q.pointer] = q.active;
          end
          if (apb_req.pwdata[CMD_COPY_BIT]) begin
            next_q.active = q.sets[q.pointer];
          end
        end
        OFS_ACTIVE: next_q.active = apb_req.pwdata[PARAM_W-1:0];
        OFS_INVERT: next_q.inv = apb_req.pwdata[LINE_W-1:0];
        default: next_q.on = q.on;
      endcase
    end
    // A used address line moved: hold off the waiting status
    if (q.st == ST_RUN && q.policy == POLICY_FREE && addr_chg) begin
      next_q.settle = SETTLE_LOAD;
    end
    case (q.st)
      ST_IDLE: begin
        if (next_q.on) begin
          next_q.backup = next_q.active;
          next_q.st     = ST_RUN;
          if (q.policy == POLICY_CTRL) begin
            next_q.cur     = FIRST_SET;
            next_q.active  = q.sets[FIRST_SET];
            next_q.loading = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (!next_q.on) begin
          if (frame_busy) begin
            next_q.st = ST_DRAIN;
          end else begin
            next_q.active = q.backup;
            next_q.st     = ST_IDLE;
          end
        end else if (trig_rise && !q.loading) begin
          // A trigger in the load cycle is ignored, as the status shows
          if (q.policy == POLICY_FREE) begin
            next_q.cur    = free_addr;
            next_q.active = q.sets[free_addr];
          end else begin
            next_q.cur    = ctrl_next;
            next_q.active = q.sets[ctrl_next];
          end
          next_q.loading = 1'b1;
        end
      end
      ST_DRAIN: begin
        if (!frame_busy) begin
          next_q.active = q.backup;
          next_q.st     = ST_IDLE;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
    next_q.waiting = (next_q.st == ST_RUN) && !next_q.loading &&
                     (next_q.settle == SETTLE_NONE) && !frame_busy;
  end

  // Stored sets clear to defaults, so unstored sets read as defaults
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q          <= '0;
      q.count    <= CNT_RST;
      q.bit0_src <= SRC_LINE1;
      q.bit1_src <= SRC_LINE2;
    end else begin
      q <= next_q;
    end
  end

  // Zero-wait slave; error only in the access phase
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pslverr = access & wr_err & apb_req.pwrite | access & ~apb_req.pwrite & (rd_word == '0) &
                           !(apb_req.paddr inside {OFS_CTRL, OFS_COUNT, OFS_TARGET, OFS_ORIGIN, OFS_PTR,
                                                   OFS_CMD, OFS_ACTIVE, OFS_INVERT, OFS_STATUS});

  assign active_params       = q.active;
  assign current_set         = q.cur;
  assign waiting_for_trigger = q.waiting;
  assign sequencer_running   = (q.st != ST_IDLE);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_drain_end;
    (q.st == ST_DRAIN) && !frame_busy;
  endsequence

  sequence s_restored;
    (q.st == ST_IDLE) && (q.active == $past(q.backup));
  endsequence

  AST_COUNT_CTRL: assert property (q.count <= CTRL_MAX_SETS && q.count >= MIN_SETS)
    else $error("set count out of range");
  AST_COUNT_FREE: assert property (q.policy == POLICY_FREE |-> q.count <= FREE_MAX_SETS)
    else $error("free mode set count above four");
  AST_NO_ALWAYS_RESTART: assert property (q.rst_src != SRC_ALWAYS)
    else $error("restart source set to always");
  AST_SAVE: assert property (wr && !wr_err && apb_req.paddr == OFS_CMD && apb_req.pwdata[CMD_SAVE_BIT]
                             |=> q.sets[$past(q.pointer)] == $past(q.active))
    else $error("save did not copy active set");
  AST_COPY: assert property (wr && apb_req.paddr == OFS_CMD && apb_req.pwdata[CMD_COPY_BIT] && q.st == ST_IDLE
                             && !q.on |=> q.active == $past(q.sets[q.pointer]))
    else $error("copy did not load active set");
  AST_FREE_SELECT: assert property (q.st == ST_RUN && q.policy == POLICY_FREE && trig_rise && !q.loading
                                    && q.on && !(wr && apb_req.paddr == OFS_CTRL)
                                    |=> q.cur == $past(free_addr) && q.loading)
    else $error("free mode picked wrong set");
  AST_SETTLE: assert property (q.st == ST_RUN && q.policy == POLICY_FREE && addr_chg
                               |=> !q.waiting [*8])
    else $error("waiting status held across line change");
  AST_DRAIN: assert property (s_drain_end |=> s_restored)
    else $error("active set not restored after frame");
  AST_HOLD_DRAIN: assert property (q.st == ST_DRAIN && frame_busy |=> q.st == ST_DRAIN)
    else $error("left drain before frame end");
  AST_SELECTOR: assert property (wr && !wr_err && apb_req.paddr == OFS_ORIGIN && q.policy == POLICY_CTRL
                                 && q.target == TGT_RESTART |=> q.rst_src == $past(apb_req.pwdata[1:0])
                                 && $stable(q.adv_src))
    else $error("selector routed source to wrong control");

endmodule : pss_sequencer

// >>> rtl/pss_sync.sv
/*
  Two-stage synchroniser for the two address lines and the frame trigger,
  with a third stage for edge and change detection.
  Assumes the inputs are quiet levels relative to the 50 MHz core clock.
*/
`timescale 1ns/100ps
module pss_sync
  import pss_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic [pss_pkg::SYNC_W-1:0] raw,
  output logic      [pss_pkg::SYNC_W-1:0] level,
  output logic      [pss_pkg::SYNC_W-1:0] rise,
  output logic      [pss_pkg::SYNC_W-1:0] change
);
  import pss_pkg::*;

  pss_sync_s q;
  pss_sync_s next_q;

  // Shift chain; the first stage feeds only the second
  always_comb begin
    next_q    = q;
    next_q.s1 = raw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Edges are taken between the settled stages only
  assign level  = q.s2;
  assign rise   = q.s2 & ~q.s3;
  assign change = q.s2 ^ q.s3;

endmodule : pss_sync

// >>> sim/pss_far_model.sv
/*
  Far-side model of the sequencer: two address input lines, the frame
  trigger and a frame busy window. Assumes the bench calls its tasks.
*/
`timescale 1ns/100ps
module pss_far_model
  import pss_pkg::*;
(
  input  wire logic                    core_clk,
  output logic [pss_pkg::LINE_W-1:0]   input_line,
  output logic                         frame_trigger,
  output logic                         frame_busy
);
  // Lines and trigger rest low from time zero
  initial begin
    input_line    = 2'h0;
    frame_trigger = 1'b0;
    frame_busy    = 1'b0;
  end

  // Levels stay put until the next call, so they hold across a trigger
  task automatic set_lines(input logic [LINE_W-1:0] lv);
    @(posedge core_clk);
    input_line <= lv;
  endtask : set_lines

  // Trigger pulse; a large n models a slow frame that is still busy
  task automatic fire(input int n);
    @(posedge core_clk);
    frame_trigger <= 1'b1;
    frame_busy    <= 1'b1;
    repeat (2) @(posedge core_clk);
    frame_trigger <= 1'b0;
    repeat (n) @(posedge core_clk);
    frame_busy <= 1'b0;
    @(posedge core_clk);
  endtask : fire
endmodule : pss_far_model

// >>> sim/test_parameter_set_sequencer.sv
/*
  Self-checking bench of the sequencer: APB master tasks note expected
  answers in a queue, a monitor compares them at each access edge.
  Assumes pss_pkg and the far-side model are compiled first.
*/
`timescale 1ns/100ps
module test_parameter_set_sequencer;
  import pss_pkg::*;
  logic                 core_clk;
  logic                 sys_rst;
  pss_apb_req_s         req;
  pss_apb_rsp_s         rsp;
  logic [LINE_W-1:0]    lines;
  logic                 trig;
  logic                 busy;
  logic [PARAM_W-1:0]   act;
  logic [IDX_W-1:0]     cur;
  logic                 wt;
  logic                 run;
  logic [PARAM_W-1:0]   v[4];
  logic [33:0]          exp_q[$];
  logic [33:0]          e;
  logic [31:0]          seed = 32'h152a8;
  int                   err_total;
  int                   check_count;
  int                   i;
  int                   ca[4] = '{1, 2, 0, 1};
  int                   fa[5] = '{1, 1, 0, 2, 3};

  pss_sequencer dut (.core_clk(core_clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .input_line(lines),
    .frame_trigger(trig), .frame_busy(busy), .active_params(act), .current_set(cur), .waiting_for_trigger(wt),
    .sequencer_running(run));
  pss_far_model far (.core_clk(core_clk), .input_line(lines), .frame_trigger(trig), .frame_busy(busy));

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
    int n;
    exp_q.push_back({w, ee, d});
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: (w ? d : 32'h0)};
    @(posedge core_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_total++;
      close_out();
    end else begin
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
    apb(1'b1, a, d, ee);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
    apb(1'b0, a, d, ee);
  endtask : rd

  // Monitor: error flag always, read data only on reads
  always @(posedge core_clk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({rsp.pslverr, (e[33] ? 32'h0 : rsp.prdata)}, e[32:0] & {1'b1, {32{!e[33]}}});
      // Output pins must agree with what the register read expects
      if (!e[33] && req.paddr == OFS_ACTIVE) begin
        check(33'(act), 33'(e[PARAM_W-1:0]));
      end
      if (!e[33] && req.paddr == OFS_STATUS) begin
        check({25'h0, wt, run, cur}, {25'h0, e[0], e[1] | e[2], e[13:8]});
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    close_out();
  end

  initial begin
    core_clk = 1'b0;
    sys_rst  = 1'b1;
    req      = '0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_COUNT, 32'h1);
    rd(OFS_ACTIVE, 32'h0);
    rd(8'h24, 32'h0, 1'b1);
    $display("Test reset done");
    // Limits of count, pointer and sources; the sequencer stays off
    wr(OFS_COUNT, 32'h0, 1'b1);
    wr(OFS_COUNT, 32'h41, 1'b1);
    wr(OFS_COUNT, 32'h40);
    rd(OFS_COUNT, 32'h40);
    wr(OFS_PTR, 32'h40, 1'b1);
    wr(OFS_PTR, 32'h3f);
    rd(OFS_PTR, 32'h3f);
    wr(OFS_TARGET, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(OFS_ORIGIN, 32'(i));
      rd(OFS_ORIGIN, 32'(i));
    end
    wr(OFS_TARGET, 32'h1);
    wr(OFS_ORIGIN, 32'h1, 1'b1);
    wr(OFS_ORIGIN, 32'h2);
    rd(OFS_ORIGIN, 32'h2);
    $display("Test limits done");
    // Fill sets 0..3, set 0 twice, then load each back
    for (i = 0; i < 5; i++) begin
      v[i % 4] = 16'(rnd());
      wr(OFS_ACTIVE, {16'h0, v[i % 4]});
      wr(OFS_PTR, 32'(i % 4));
      wr(OFS_CMD, 32'h1);
    end
    for (i = 0; i < 4; i++) begin
      wr(OFS_PTR, 32'(i));
      wr(OFS_CMD, 32'h2);
      rd(OFS_ACTIVE, {16'h0, v[i]});
    end
    wr(OFS_PTR, 32'h9);
    wr(OFS_CMD, 32'h2);
    rd(OFS_ACTIVE, 32'h0);
    $display("Test store done");
    // Controlled: advance on line 2, restart on line 1, three sets
    wr(OFS_ACTIVE, 32'h5a5a);
    wr(OFS_COUNT, 32'h3);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_ACTIVE, {16'h0, v[0]});
    far.set_lines(2'b10);
    for (i = 0; i < 4; i++) begin
      far.fire(6 + int'(rnd() & 32'h7));
      rd(OFS_ACTIVE, {16'h0, v[ca[i]]});
      rd(OFS_STATUS, 32'h3 | (32'(ca[i]) << 8));
    end
    far.set_lines(2'b01);
    far.fire(6);
    rd(OFS_ACTIVE, {16'h0, v[0]});
    wr(OFS_CTRL, 32'h0);
    rd(OFS_ACTIVE, 32'h5a5a);
    $display("Test controlled done");
    // Free selection with four sets, lines form the address
    wr(OFS_CTRL, 32'h2);
    wr(OFS_COUNT, 32'h5, 1'b1);
    wr(OFS_COUNT, 32'h4);
    wr(OFS_CTRL, 32'h3);
    for (i = 0; i < 5; i++) begin
      far.set_lines(2'(fa[i]));
      repeat (60) @(posedge core_clk);
      far.fire(6 + int'(rnd() & 32'h7));
      rd(OFS_ACTIVE, {16'h0, v[fa[i]]});
      rd(OFS_STATUS, 32'h3 | (32'(fa[i]) << 8));
    end
    far.set_lines(2'b00);
    repeat (6) @(posedge core_clk);
    rd(OFS_STATUS, 32'h0302);
    repeat (60) @(posedge core_clk);
    rd(OFS_STATUS, 32'h0303);
    // Inverted lines
    wr(OFS_CTRL, 32'h2);
    wr(OFS_INVERT, 32'h3);
    wr(OFS_CTRL, 32'h3);
    far.set_lines(2'b10);
    repeat (60) @(posedge core_clk);
    far.fire(6);
    rd(OFS_ACTIVE, {16'h0, v[1]});
    // Two sets: line 2 takes no part in the address
    wr(OFS_CTRL, 32'h2);
    wr(OFS_INVERT, 32'h0);
    wr(OFS_COUNT, 32'h2);
    wr(OFS_ACTIVE, 32'h1234);
    wr(OFS_CTRL, 32'h3);
    far.set_lines(2'b10);
    repeat (60) @(posedge core_clk);
    far.fire(6);
    rd(OFS_ACTIVE, {16'h0, v[0]});
    far.set_lines(2'b11);
    repeat (60) @(posedge core_clk);
    far.fire(6);
    rd(OFS_ACTIVE, {16'h0, v[1]});
    $display("Test free done");
    // Switch off mid-frame: frame drains, then old active comes back
    fork
      far.fire(40);
    join_none
    repeat (8) @(posedge core_clk);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_STATUS, 32'h0104);
    wait fork;
    repeat (3) @(posedge core_clk);
    rd(OFS_ACTIVE, 32'h1234);
    // Free-mode address bit source: only the two lines are accepted
    wr(OFS_TARGET, 32'h0);
    wr(OFS_ORIGIN, 32'h1, 1'b1);
    wr(OFS_ORIGIN, 32'h3);
    rd(OFS_ORIGIN, 32'h3);
    $display("Test drain done");
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule : test_parameter_set_sequencer
